/* core/prf_top.sv */
// pci read prefetch and buffering control with apb registers
// How it works
// - interrupt pin reads 01h always
// - pin field bits 15:8, read-only
// - minimum grant bits 23:16, read-only zero
// - maximum latency bits 31:24, read-only zero
// - park bit picks last master or bridge
// - bit disables dynamic prefetch control
// - completion prediction on while bit is 0
// - read multiple mode 00: one line
// - mode 01: full, keep after bridge stop
// - mode 10: full prefetch, reset value
// - mode 11: full, keep after any stop
// - read line mode 00: one line, reset
// - mode 01: full, keep after master stop
// - read line mode 10: full prefetch
// - mode 11: full, keep after any stop
// - full prefetch sized by byte count code
// assumes synchronous inputs, one apb master, pulses one cycle long
// assumes the stop and expiry pulses come from the pci side of the bridge
// assumes the header word is the same in forward and reverse operation
// assumes one pci read at a time is open; a new read replaces the old one
`timescale 1ns/1ns
module prf_top
   import prf_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic [1:0] req_cmd,
   input wire logic req_prefetchable,
   input wire logic [12:0] req_bytes,
   input wire logic term_by_master,
   input wire logic term_by_bridge,
   input wire logic discard_expired,
   output logic fetch_valid,
   output logic fetch_full,
   output logic [12:0] fetch_bytes,
   output logic retain_data,
   output logic park_on_bridge,
   output logic dyn_prefetch_en,
   output logic cmpl_predict_en
);
   // register storage and bus decode
   logic [7:0] irq_line; // software scratch for interrupt routing
   logic [15:0] bufctl; // buffering control word
   logic [15:0] next_bufctl; // write-merged control word
   logic setup; // apb setup cycle
   logic wr_take; // write accepted this edge
   logic hit; // address maps to a register
   logic [31:0] rd_word; // read mux
   logic keep_master; // current read keeps on master stop
   logic keep_bridge; // current read keeps on bridge stop
   logic in_read; // a prefetch read is open
   logic keep_now; // stop that keeps leftovers
   // carrier of one read's policy between core and decoder
   prf_decide_if dif ();

   // policy decoder
   // purely combinational; every result it gives is registered below
   prf_decide u_decide (
      .dif(dif)
   );

   // decoder inputs
   assign dif.cmd = req_cmd;
   assign dif.prefetchable = req_prefetchable;
   assign dif.req_bytes = req_bytes;
   assign dif.rm_mode = bufctl[PRF_RM_LSB +: 2];
   assign dif.rl_mode = bufctl[PRF_RL_LSB +: 2];
   assign dif.bc_code = bufctl[PRF_BC_LSB +: 3];

   // bus phase decode
   // no wait states: pready rises at the edge after the setup cycle
   assign setup = psel & ~penable;
   assign wr_take = psel & penable & pready & pwrite;
   assign hit = (paddr == PRF_OFS_HEADER) || (paddr == PRF_OFS_BUFCTL);
   assign next_bufctl = (bufctl & ~PRF_BUFCTL_WMASK) | (pwdata[15:0] & PRF_BUFCTL_WMASK);

   // read mux; header fields other than the interrupt line are constants in both bridge modes
   // only the interrupt line needs storage; the other header fields are wired
   always_comb begin
      rd_word = 32'h0000_0000;
      if (paddr == PRF_OFS_HEADER) begin
         rd_word[PRF_IRQ_LINE_LSB +: 8] = irq_line;
         rd_word[PRF_IRQ_PIN_LSB +: 8] = PRF_IRQ_PIN_VAL;
         rd_word[PRF_MIN_GNT_LSB +: 8] = PRF_MIN_GNT_VAL;
         rd_word[PRF_MAX_LAT_LSB +: 8] = PRF_MAX_LAT_VAL;
      end else if (paddr == PRF_OFS_BUFCTL) begin
         rd_word[15:0] = bufctl;
      end
   end

   // apb answer: one access cycle, data captured in setup
   // latching in setup leaves the access cycle free of any address decode
   always_ff @(posedge clock) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
         end
      end
   end

   // writable registers; read-only header fields ignore writes
   // a write lands only at the access edge, never in the setup cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_line <= PRF_IRQ_LINE_RST;
         bufctl <= PRF_BUFCTL_RST;
      end else if (wr_take) begin
         if (paddr == PRF_OFS_HEADER) begin
            irq_line <= pwdata[PRF_IRQ_LINE_LSB +: 8];
         end else if (paddr == PRF_OFS_BUFCTL) begin
            bufctl <= next_bufctl;
         end
      end
   end

   // control levels driven from the control word
   // registered again so that each output starts at a flip-flop
   always_ff @(posedge clock) begin
      if (reset) begin
         park_on_bridge <= 1'b0;
         dyn_prefetch_en <= 1'b1;
         cmpl_predict_en <= 1'b1;
      end else begin
         park_on_bridge <= bufctl[PRF_PARK_BIT];
         dyn_prefetch_en <= ~bufctl[PRF_DYN_DIS_BIT];
         cmpl_predict_en <= ~bufctl[PRF_PRED_DIS_BIT];
      end
   end

   // upstream request issue, one cycle after the pci read
   // size and kind hold until the next read; only the valid strobe pulses
   always_ff @(posedge clock) begin
      if (reset) begin
         fetch_valid <= 1'b0;
         fetch_full <= 1'b0;
         fetch_bytes <= 13'h0000;
      end else begin
         fetch_valid <= req_valid;
         if (req_valid) begin
            fetch_full <= dif.full;
            fetch_bytes <= dif.bytes;
         end
      end
   end

   // leftover policy of the read in progress
   // a new read wins over a stop in the same cycle and opens a fresh read
   always_ff @(posedge clock) begin
      if (reset) begin
         in_read <= 1'b0;
         keep_master <= 1'b0;
         keep_bridge <= 1'b0;
      end else if (req_valid) begin
         in_read <= 1'b1;
         keep_master <= dif.keep_master;
         keep_bridge <= dif.keep_bridge;
      end else if (term_by_master | term_by_bridge) begin
         in_read <= 1'b0;
      end
   end

   // stop that must keep leftovers, per mode
   assign keep_now = in_read & ((term_by_master & keep_master) | (term_by_bridge & keep_bridge));

   // kept data flag; a new keep wins over a same-cycle expiry
   // a new read also drops kept data, as it needs fresh data anyway
   always_ff @(posedge clock) begin
      if (reset) begin
         retain_data <= 1'b0;
      end else if (keep_now) begin
         retain_data <= 1'b1;
      end else if (discard_expired | req_valid) begin
         retain_data <= 1'b0;
      end
   end

   // checks of the register bus, the policy and the leftover handling
   // all of them run on the bridge clock and stay quiet during reset
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   a_pin_readback: assert property ((setup & ~pwrite & (paddr == PRF_OFS_HEADER))
      |=> prdata[31:8] == 24'h000001)
      else $error("header read shows wrong fixed fields");
   a_pin_readonly: assert property ((wr_take & (paddr == PRF_OFS_HEADER))
      ##[1:2] (setup & ~pwrite & (paddr == PRF_OFS_HEADER)) |=> prdata[15:8] == 8'h01)
      else $error("interrupt pin changed by a write");
   a_grant_zero: assert property ((setup & ~pwrite & (paddr == PRF_OFS_HEADER))
      |=> prdata[23:16] == 8'h00)
      else $error("minimum grant not zero");
   a_latency_zero: assert property ((setup & ~pwrite & (paddr == PRF_OFS_HEADER))
      |=> prdata[31:24] == 8'h00)
      else $error("maximum latency not zero");
   a_park_follow: assert property ((wr_take & (paddr == PRF_OFS_BUFCTL))
      |-> ##2 park_on_bridge == $past(pwdata[PRF_PARK_BIT], 2))
      else $error("park select does not follow the control bit");
   a_dyn_follow: assert property ((wr_take & (paddr == PRF_OFS_BUFCTL))
      |-> ##2 dyn_prefetch_en == !$past(pwdata[PRF_DYN_DIS_BIT], 2))
      else $error("dynamic prefetch enable wrong");
   a_pred_follow: assert property ((wr_take & (paddr == PRF_OFS_BUFCTL))
      |-> ##2 cmpl_predict_en == !$past(pwdata[PRF_PRED_DIS_BIT], 2))
      else $error("completion prediction enable wrong");
   a_mrm_one_line: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRM)
      & (bufctl[PRF_RM_LSB +: 2] == 2'b00)) |=> fetch_valid & !fetch_full
      & (fetch_bytes == PRF_LINE_BYTES))
      else $error("read multiple mode 00 not one line");
   a_mrl_one_line: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRL)
      & (bufctl[PRF_RL_LSB +: 2] == 2'b00)) |=> fetch_bytes == PRF_LINE_BYTES)
      else $error("read line mode 00 not one line");
   a_full_sized: assert property ((req_valid & dif.full)
      |=> fetch_full & (fetch_bytes == prf_max_bytes($past(bufctl[PRF_BC_LSB +: 3]))))
      else $error("full prefetch size wrong");
   a_nonpref_exact: assert property ((req_valid & !req_prefetchable)
      |=> !fetch_full & (fetch_bytes == $past(req_bytes)))
      else $error("non-prefetchable read not exact");
   a_keep_all: assert property ((in_read & keep_master & keep_bridge & (term_by_master | term_by_bridge))
      |=> retain_data)
      else $error("leftover data not kept");
   a_discard_release: assert property ((discard_expired & !keep_now) |=> !retain_data)
      else $error("kept data not released on expiry");

   // apb answer timing and refusal of unmapped addresses
   // each setup gets exactly one access cycle
   a_ready_after: assert property (setup |=> pready)
      else $error("no ready in the access cycle");
   a_ready_single: assert property (!setup |=> !pready)
      else $error("ready without a setup cycle");
   a_unmapped_err: assert property ((setup & (paddr != PRF_OFS_HEADER) & (paddr != PRF_OFS_BUFCTL))
      |=> pready & pslverr & (prdata == 32'h0000_0000))
      else $error("unmapped address not refused");
   a_bufctl_reserved: assert property ((wr_take & (paddr == PRF_OFS_BUFCTL))
      |=> (bufctl & ~PRF_BUFCTL_WMASK) == 16'h0000)
      else $error("read-only control bits took a write");

   // one upstream request per pci read, one cycle later, held until the next
   a_fetch_follow: assert property (req_valid |=> fetch_valid)
      else $error("read not passed upstream");
   a_fetch_single: assert property (!req_valid |=> !fetch_valid)
      else $error("upstream request without a read");
   a_fetch_hold: assert property (!req_valid |=> $stable(fetch_bytes) & $stable(fetch_full))
      else $error("request size changed without a read");
   a_plain_exact: assert property ((req_valid & (!req_prefetchable | (req_cmd == PRF_CMD_MR)
      | (req_cmd == 2'b11))) |=> !fetch_full & !keep_master & !keep_bridge)
      else $error("plain read prefetched or kept");

   // full prefetch in mode 10 for both commands, default size 512 bytes
   a_mrm_full: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRM)
      & (bufctl[PRF_RM_LSB +: 2] == 2'b10)) |=> fetch_valid & fetch_full)
      else $error("read multiple mode 10 not full");
   a_mrl_full: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRL)
      & (bufctl[PRF_RL_LSB +: 2] == 2'b10)) |=> fetch_valid & fetch_full)
      else $error("read line mode 10 not full");
   a_size_default: assert property ((req_valid & dif.full & ((bufctl[PRF_BC_LSB +: 3] == 3'h0)
      | (bufctl[PRF_BC_LSB +: 3] == 3'h3) | (bufctl[PRF_BC_LSB +: 3] == 3'h7))) |=> fetch_bytes == 13'h0200)
      else $error("default byte count not 512");

   // leftovers kept after the stop that the mode names
   // the read must still be open: no new read and no stop in between
   a_mrm_keep_bridge: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRM)
      & (bufctl[PRF_RM_LSB +: 2] == 2'b01)) ##1 !(req_valid | term_by_master | term_by_bridge)
      ##1 (term_by_bridge & !req_valid) |=> retain_data)
      else $error("read multiple mode 01 lost leftovers");
   a_mrl_keep_master: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRL)
      & (bufctl[PRF_RL_LSB +: 2] == 2'b01)) ##1 !(req_valid | term_by_master | term_by_bridge)
      ##1 (term_by_master & !req_valid) |=> retain_data)
      else $error("read line mode 01 lost leftovers");
   a_mrm_keep_any: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRM)
      & (bufctl[PRF_RM_LSB +: 2] == 2'b11)) ##1 !(req_valid | term_by_master | term_by_bridge)
      ##1 ((term_by_master | term_by_bridge) & !req_valid) |=> retain_data)
      else $error("read multiple mode 11 lost leftovers");
   a_mrl_keep_any: assert property ((req_valid & req_prefetchable & (req_cmd == PRF_CMD_MRL)
      & (bufctl[PRF_RL_LSB +: 2] == 2'b11)) ##1 !(req_valid | term_by_master | term_by_bridge)
      ##1 ((term_by_master | term_by_bridge) & !req_valid) |=> retain_data)
      else $error("read line mode 11 lost leftovers");
   a_read_release: assert property ((req_valid & !keep_now) |=> !retain_data)
      else $error("kept data survives a new read");

   // main scenarios seen at least once
   c_keep_then_drop: cover property (keep_now ##[1:20] discard_expired);
   c_full_read: cover property (req_valid & dif.full);
   c_bad_address: cover property (pready & pslverr);
   c_bridge_keep: cover property (keep_now & term_by_bridge);
   c_header_write: cover property (wr_take & (paddr == PRF_OFS_HEADER));
endmodule

/* pkg/prf_pkg.sv */
// constants, types and helpers of the read prefetch control block
// assumes an apb slave with 32-bit data and byte addresses
package prf_pkg;
   // register byte addresses
   localparam logic [11:0] PRF_OFS_HEADER = 12'h03C;
   localparam logic [11:0] PRF_OFS_BUFCTL = 12'h040;
   // header word fields
   localparam int PRF_IRQ_LINE_LSB = 0;
   localparam int PRF_IRQ_PIN_LSB = 8;
   localparam int PRF_MIN_GNT_LSB = 16;
   localparam int PRF_MAX_LAT_LSB = 24;
   localparam logic [7:0] PRF_IRQ_LINE_RST = 8'h00;
   localparam logic [7:0] PRF_IRQ_PIN_VAL = 8'h01;
   localparam logic [7:0] PRF_MIN_GNT_VAL = 8'h00;
   localparam logic [7:0] PRF_MAX_LAT_VAL = 8'h00;
   // buffering control fields
   localparam int PRF_PARK_BIT = 0;
   localparam int PRF_DYN_DIS_BIT = 1;
   localparam int PRF_PRED_DIS_BIT = 2;
   localparam int PRF_RM_LSB = 4;
   localparam int PRF_RL_LSB = 6;
   localparam int PRF_BC_LSB = 12;
   localparam logic [15:0] PRF_BUFCTL_WMASK = 16'h70F7;
   localparam logic [15:0] PRF_BUFCTL_RST = 16'h0020;
   // transfer sizes in bytes
   localparam logic [12:0] PRF_LINE_BYTES = 13'h0020;
   // prefetch mode codes
   typedef enum logic [1:0] {
      PRF_ONE_LINE = 2'b00,
      PRF_FULL_KEEP_ONE = 2'b01,
      PRF_FULL = 2'b10,
      PRF_FULL_KEEP_ALL = 2'b11
   } prf_mode_type;
   // pci memory read commands
   typedef enum logic [1:0] {
      PRF_CMD_MR = 2'b00,
      PRF_CMD_MRL = 2'b01,
      PRF_CMD_MRM = 2'b10
   } prf_cmd_type;
   // maximum read request byte count from its code
   function automatic logic [12:0] prf_max_bytes(input logic [2:0] code);
      case (code)
         3'h1: prf_max_bytes = 13'h0080;
         3'h2: prf_max_bytes = 13'h0100;
         3'h4: prf_max_bytes = 13'h0400;
         3'h5: prf_max_bytes = 13'h0800;
         3'h6: prf_max_bytes = 13'h1000;
         default: prf_max_bytes = 13'h0200;
      endcase
   endfunction
endpackage

/* pkg/prf_decide_if.sv */
// signals between the control core and its prefetch policy decoder
// assumes both ends share the bridge clock
`timescale 1ns/1ns
interface prf_decide_if;
   logic [1:0] cmd; // pci read command
   logic prefetchable; // address in prefetchable range
   logic [12:0] req_bytes; // bytes the master asked for
   logic [1:0] rm_mode; // read multiple mode
   logic [1:0] rl_mode; // read line mode
   logic [2:0] bc_code; // maximum byte count code
   logic full; // full prefetch chosen
   logic [12:0] bytes; // size of the upstream request
   logic keep_master; // keep leftovers on master stop
   logic keep_bridge; // keep leftovers on bridge stop
   modport core (output cmd, prefetchable, req_bytes, rm_mode, rl_mode, bc_code,
      input full, bytes, keep_master, keep_bridge);
   modport decide (input cmd, prefetchable, req_bytes, rm_mode, rl_mode, bc_code,
      output full, bytes, keep_master, keep_bridge);
endinterface

/* core/prf_decide.sv */
// prefetch policy decoder: chooses size and leftover handling of a read
// assumes the core registers whatever it takes from here
`timescale 1ns/1ns
module prf_decide
   import prf_pkg::*;
(
   prf_decide_if.decide dif
);
   // policy from command, range and modes
   always_comb begin
      dif.full = 1'b0;
      dif.keep_master = 1'b0;
      dif.keep_bridge = 1'b0;
      dif.bytes = dif.req_bytes;
      // outside a prefetchable range only the asked data is fetched
      if (dif.prefetchable) begin
         case (dif.cmd)
            PRF_CMD_MRM: begin
               case (dif.rm_mode)
                  PRF_ONE_LINE: dif.bytes = PRF_LINE_BYTES;
                  PRF_FULL_KEEP_ONE: begin
                     dif.full = 1'b1;
                     dif.keep_bridge = 1'b1;
                  end
                  PRF_FULL: dif.full = 1'b1;
                  default: begin
                     dif.full = 1'b1;
                     dif.keep_master = 1'b1;
                     dif.keep_bridge = 1'b1;
                  end
               endcase
            end
            PRF_CMD_MRL: begin
               case (dif.rl_mode)
                  PRF_ONE_LINE: dif.bytes = PRF_LINE_BYTES;
                  PRF_FULL_KEEP_ONE: begin
                     dif.full = 1'b1;
                     dif.keep_master = 1'b1;
                  end
                  PRF_FULL: dif.full = 1'b1;
                  default: begin
                     dif.full = 1'b1;
                     dif.keep_master = 1'b1;
                     dif.keep_bridge = 1'b1;
                  end
               endcase
            end
            default: dif.bytes = dif.req_bytes;
         endcase
         // full prefetch is sized by the byte count code
         if (dif.full) begin
            dif.bytes = prf_max_bytes(dif.bc_code);
         end
      end
   end
endmodule

/* sim/prf_pci_master.sv */
// pci master model: presents memory reads and ends them
// assumes the bench calls its tasks from one process
`timescale 1ns/1ns
module prf_pci_master
   import prf_pkg::*;
(
   input wire logic clock,
   output logic req_valid,
   output logic [1:0] req_cmd,
   output logic req_prefetchable,
   output logic [12:0] req_bytes,
   output logic term_by_master,
   output logic term_by_bridge,
   output logic discard_expired
);
   // idle bus at time zero
   initial begin
      req_valid = 1'b0;
      req_cmd = 2'b00;
      req_prefetchable = 1'b0;
      req_bytes = 13'h0000;
      term_by_master = 1'b0;
      term_by_bridge = 1'b0;
      discard_expired = 1'b0;
   end
   // one read, then a stop: 1 by master, 2 by bridge, 0 none
   task automatic read(input logic [1:0] cmd, input logic pf, input logic [12:0] n, input int stop);
      @(posedge clock);
      req_valid <= 1'b1;
      req_cmd <= cmd;
      req_prefetchable <= pf;
      req_bytes <= n;
      @(posedge clock);
      // released fields show the inverse, never the old value
      req_valid <= 1'b0;
      req_cmd <= ~cmd;
      req_prefetchable <= ~pf;
      req_bytes <= ~n;
      @(posedge clock);
      term_by_master <= (stop == 1);
      term_by_bridge <= (stop == 2);
      @(posedge clock);
      term_by_master <= 1'b0;
      term_by_bridge <= 1'b0;
   endtask
   // one discard timer expiry pulse
   task automatic expire();
      @(posedge clock);
      discard_expired <= 1'b1;
      @(posedge clock);
      discard_expired <= 1'b0;
   endtask
endmodule

/* sim/prf_top_tb.sv */
// self-checking bench of the read prefetch control block
// assumes apb answers with one access cycle, fetch one cycle after a read
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module prf_top_tb
   import prf_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, req_valid, req_prefetchable, term_by_master, term_by_bridge;
   logic [1:0] req_cmd;
   logic [12:0] req_bytes, fetch_bytes;
   logic discard_expired, fetch_valid, fetch_full, retain_data;
   logic park_on_bridge, dyn_prefetch_en, cmpl_predict_en;
   int n_fail = 0;
   int cmp_count = 0;
   logic [32:0] apb_q[$]; // expected {pslverr, prdata}
   logic [13:0] fet_q[$]; // expected {fetch_full, fetch_bytes}
   // full prefetch size for each byte count code
   logic [12:0] sz_tab[8] = '{13'h0200, 13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, 13'h1000, 13'h0200};
   always #5 clock = ~clock;
   prf_top i_prf_top (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_prefetchable(req_prefetchable), .req_bytes(req_bytes),
      .term_by_master(term_by_master), .term_by_bridge(term_by_bridge), .discard_expired(discard_expired),
      .fetch_valid(fetch_valid), .fetch_full(fetch_full), .fetch_bytes(fetch_bytes), .retain_data(retain_data),
      .park_on_bridge(park_on_bridge), .dyn_prefetch_en(dyn_prefetch_en), .cmpl_predict_en(cmpl_predict_en));
   prf_pci_master i_prf_pci_master (.clock(clock), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_prefetchable(req_prefetchable), .req_bytes(req_bytes), .term_by_master(term_by_master),
      .term_by_bridge(term_by_bridge), .discard_expired(discard_expired));
   // verdict and end of run
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer; its answer is noted for the monitor
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
      int k;
      apb_q.push_back(exp);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // monitor: each answer takes the oldest note
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         if (apb_q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK({pslverr, prdata}, apb_q.pop_front())
      end
      if (fetch_valid === 1'b1) begin
         if (fet_q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK({fetch_full, fetch_bytes}, fet_q.pop_front())
      end
   end
   // watchdog against a hang
   initial begin
      #400000;
      n_fail++;
      complete_run();
   end
   // main sequence
   initial begin
      int s;
      logic [2:0] bc;
      logic [12:0] n;
      logic [1:0] m;
      logic full;
      logic keep;
      s = $urandom(32'hf0d91cf8);
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, PRF_OFS_HEADER, 32'h0, {1'b0, 32'h00000100});
      apb(1'b0, PRF_OFS_BUFCTL, 32'h0, {1'b0, 32'h00000020});
      `CHK({park_on_bridge, dyn_prefetch_en, cmpl_predict_en}, 3'b011)
      $display("test reset values done");
      // read-only bits hold, unmapped place answers with an error
      apb(1'b1, PRF_OFS_HEADER, 32'hFFFFFFFF, 33'h0);
      apb(1'b0, PRF_OFS_HEADER, 32'h0, {1'b0, 32'h000001FF});
      apb(1'b0, 12'h044, 32'h0, {1'b1, 32'h00000000});
      apb(1'b1, PRF_OFS_BUFCTL, 32'h0000FFFF, 33'h0);
      apb(1'b0, PRF_OFS_BUFCTL, 32'h0, {1'b0, 32'h000070F7});
      `CHK({park_on_bridge, dyn_prefetch_en, cmpl_predict_en}, 3'b100)
      $display("test register access done");
      // every mode for line and multiple reads, both stoppers
      for (int i = 0; i < 4; i++) begin
         bc = 3'($urandom_range(0, 7));
         m = 2'(i);
         apb(1'b1, PRF_OFS_BUFCTL, {17'h0, bc, 4'h0, m, m, 4'h0}, 33'h0);
         for (int c = 1; c < 3; c++) begin
            for (int st = 1; st < 3; st++) begin
               n = 13'($urandom_range(1, 4096));
               full = (m != 2'b00);
               fet_q.push_back({full, full ? sz_tab[bc] : PRF_LINE_BYTES});
               i_prf_pci_master.read(2'(c), 1'b1, n, st);
               #1;
               keep = (m == 2'b11) || (m == 2'b01 && st == c);
               `CHK(retain_data, keep)
               i_prf_pci_master.expire();
               #1;
               `CHK(retain_data, 1'b0)
            end
         end
      end
      $display("test prefetch modes done");
      // plain and non-prefetchable reads fetch only what was asked
      n = 13'($urandom_range(1, 4096));
      fet_q.push_back({1'b0, n});
      i_prf_pci_master.read(PRF_CMD_MRM, 1'b0, n, 0);
      fet_q.push_back({1'b0, ~n});
      i_prf_pci_master.read(PRF_CMD_MR, 1'b1, ~n, 0);
      repeat (4) @(posedge clock);
      `CHK(fet_q.size() + apb_q.size(), 0)
      $display("test plain reads done");
      complete_run();
   end
endmodule
